/* hdl/vpb_pkg.sv */
package vpb_pkg;
    // ---------------------------------------------------------------
    // Register byte addresses
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_CMD0 = 8'h00;
    localparam logic [7:0] ADDR_CMD1 = 8'h04;
    localparam logic [7:0] ADDR_CMD2 = 8'h08;
    localparam logic [7:0] ADDR_CMD3 = 8'h0C;
    localparam logic [7:0] ADDR_CTRL = 8'h10;
    localparam logic [7:0] ADDR_STAT = 8'h14;
    localparam logic [7:0] ADDR_RDLO = 8'h18;
    localparam logic [7:0] ADDR_RDHI = 8'h1C;
    localparam logic [7:0] ADDR_ISTAT = 8'h20;
    localparam logic [7:0] ADDR_IMASK = 8'h24;
    // ---------------------------------------------------------------
    // Command block byte positions and codes
    // ---------------------------------------------------------------
    localparam int BYTE_SIG = 0;
    localparam int BYTE_SUB = 1;
    localparam int BYTE_ACT = 2;
    localparam int BYTE_MASK = 3;
    localparam int BYTE_CNT = 4;
    localparam int BYTE_WR0 = 5;
    localparam int NUM_TF = 8;
    localparam logic [7:0] SUBCMD_CODE = 8'h24;
    localparam logic [7:0] SIG_RESET = 8'h5A; // Arbitrary default
    localparam int ACT_RDONLY_BIT = 0;
    localparam logic [8:0] SECT_ZERO = 9'h100;
    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_SIG_LSB = 8;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_SECT_LSB = 16;
    localparam int EV_DONE = 0;
    localparam int EV_FAIL = 1;
    localparam int EV_REJ = 2;
    localparam int NUM_EV = 3;
    // ---------------------------------------------------------------
    // Taskfile addressing and bus responses
    // ---------------------------------------------------------------
    localparam logic [2:0] TF_ALT_ADDR = 3'h6;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* hdl/vpb_seq_if.sv */
`timescale 1ns/10ps
// Launch and result of one taskfile register walk
interface vpb_seq_if;
    logic start;
    logic read_only;
    logic [7:0] mask;
    logic [63:0] wbytes;
    logic busy;
    logic done;
    logic [63:0] rbytes;
    modport ctl (output start, read_only, mask, wbytes,
                 input busy, done, rbytes);
    modport seq (input start, read_only, mask, wbytes,
                 output busy, done, rbytes);
endinterface

/* hdl/vpb_seq.sv */
`timescale 1ns/10ps
module vpb_seq #(
    parameter int NREG = 8
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Control side
    vpb_seq_if.seq sif,
    // Drive taskfile port
    output logic tf_alt,
    output logic [2:0] tf_addr,
    output logic tf_rd,
    output logic tf_wr,
    output logic [7:0] tf_wdata,
    input wire logic [7:0] tf_rdata,
    input wire logic tf_ack
);
    generate
        if (NREG != vpb_pkg::NUM_TF) begin : g_bad
            $error("vpb_seq serves exactly eight taskfile registers");
        end
    endgenerate

    typedef enum logic [1:0] {S_IDLE, S_SCAN, S_WAIT} vpb_state_t;
    vpb_state_t state_r;
    logic [2:0] idx_r;
    logic rdonly_r;
    logic [7:0] mask_r;
    logic [63:0] wb_r;
    logic [63:0] rb_r;
    logic done_r;
    logic last;
    logic sel;

    assign last = (idx_r == 3'h7);
    assign sel = mask_r[idx_r];
    assign sif.busy = (state_r != S_IDLE);
    assign sif.done = done_r;
    assign sif.rbytes = rb_r;

    // Walk mask bits upward, one access at a time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= S_IDLE;
            idx_r <= 3'h0;
            rdonly_r <= 1'b0;
            mask_r <= 8'h00;
            wb_r <= 64'h0000_0000_0000_0000;
            rb_r <= 64'h0000_0000_0000_0000;
            done_r <= 1'b0;
            tf_alt <= 1'b0;
            tf_addr <= 3'h0;
            tf_rd <= 1'b0;
            tf_wr <= 1'b0;
            tf_wdata <= 8'h00;
        end else begin
            done_r <= 1'b0;
            case (state_r)
                S_IDLE: begin
                    if (sif.start) begin
                        state_r <= S_SCAN;
                        idx_r <= 3'h0;
                        rdonly_r <= sif.read_only;
                        mask_r <= sif.mask;
                        wb_r <= sif.wbytes;
                        rb_r <= 64'h0000_0000_0000_0000;
                    end
                end
                S_SCAN: begin
                    if (sel) begin
                        tf_alt <= (idx_r == 3'h0);
                        tf_addr <= (idx_r == 3'h0) ?
                            vpb_pkg::TF_ALT_ADDR : idx_r;
                        tf_rd <= rdonly_r;
                        tf_wr <= !rdonly_r;
                        tf_wdata <= wb_r[idx_r*8 +: 8];
                        state_r <= S_WAIT;
                    end else if (last) begin
                        state_r <= S_IDLE;
                        done_r <= 1'b1;
                    end else begin
                        idx_r <= idx_r + 3'h1;
                    end
                end
                S_WAIT: begin
                    if (tf_ack) begin
                        tf_rd <= 1'b0;
                        tf_wr <= 1'b0;
                        if (rdonly_r) begin
                            rb_r[idx_r*8 +: 8] <= tf_rdata;
                        end
                        if (last) begin
                            state_r <= S_IDLE;
                            done_r <= 1'b1;
                        end else begin
                            idx_r <= idx_r + 3'h1;
                            state_r <= S_SCAN;
                        end
                    end
                end
                default: begin
                    state_r <= S_IDLE;
                end
            endcase
        end
    end
endmodule

/* hdl/vpb_top.sv */
// The address map and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/10ps
module vpb_top (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Taskfile register port
    output logic tf_alt,
    output logic [2:0] tf_addr,
    output logic tf_rd,
    output logic tf_wr,
    output logic [7:0] tf_wdata,
    input wire logic [7:0] tf_rdata,
    input wire logic tf_ack,
    // Interrupt
    output logic irq
);
    // ---------------------------------------------------------------
    // Storage
    // ---------------------------------------------------------------
    logic [127:0] cmd_r;
    logic [7:0] sig_r;
    logic busy_r;
    logic [8:0] sect_r;
    logic [63:0] res_r;
    logic [2:0] ist_r;
    logic [2:0] imask_r;
    logic irq_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic awready_r;
    logic wready_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic arready_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;

    vpb_seq_if sif ();

    vpb_seq #(
        .NREG(vpb_pkg::NUM_TF)
    ) u_seq (
        .aclk(aclk),
        .aresetn(aresetn),
        .sif(sif.seq),
        .tf_alt(tf_alt),
        .tf_addr(tf_addr),
        .tf_rd(tf_rd),
        .tf_wr(tf_wr),
        .tf_wdata(tf_wdata),
        .tf_rdata(tf_rdata),
        .tf_ack(tf_ack)
    );

    // ---------------------------------------------------------------
    // Write channel decode
    // ---------------------------------------------------------------
    wire wr_go = !awready_r && !wready_r && !bvalid_r;
    wire [31:0] bmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}},
                         {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
    wire [31:0] wbits = wdata_r & bmask;
    wire sel_cmd = (awaddr_r[7:4] == 4'h0);
    wire sel_ctrl = (awaddr_r == vpb_pkg::ADDR_CTRL);
    wire sel_ist = (awaddr_r == vpb_pkg::ADDR_ISTAT);
    wire sel_imask = (awaddr_r == vpb_pkg::ADDR_IMASK);
    wire wr_ro = (awaddr_r == vpb_pkg::ADDR_STAT) ||
                 (awaddr_r == vpb_pkg::ADDR_RDLO) ||
                 (awaddr_r == vpb_pkg::ADDR_RDHI);
    wire wr_ok = sel_cmd || sel_ctrl || sel_ist || sel_imask || wr_ro;
    wire [1:0] widx = awaddr_r[3:2];
    wire start_p = wr_go && sel_ctrl &&
                   wbits[vpb_pkg::CTRL_START_BIT];

    // ---------------------------------------------------------------
    // Command block fields
    // ---------------------------------------------------------------
    wire [7:0] b_sig = cmd_r[vpb_pkg::BYTE_SIG*8 +: 8];
    wire [7:0] b_sub = cmd_r[vpb_pkg::BYTE_SUB*8 +: 8];
    wire [7:0] b_act = cmd_r[vpb_pkg::BYTE_ACT*8 +: 8];
    wire [7:0] b_mask = cmd_r[vpb_pkg::BYTE_MASK*8 +: 8];
    wire [7:0] b_cnt = cmd_r[vpb_pkg::BYTE_CNT*8 +: 8];
    wire sig_ok = (b_sig == sig_r);
    wire sub_ok = (b_sub == vpb_pkg::SUBCMD_CODE);
    wire recog = sig_ok && sub_ok;
    wire cnt_ok = ((b_cnt & (b_cnt - 8'h01)) == 8'h00);
    wire [8:0] sect = (b_cnt == 8'h00) ? vpb_pkg::SECT_ZERO :
                      {1'b0, b_cnt};
    wire go = start_p && !busy_r && !sif.busy;
    wire launch = go && recog && cnt_ok;
    wire ev_fail = go && recog && !cnt_ok;
    wire ev_rej = go && !recog;
    wire [2:0] ev = {ev_rej, ev_fail, sif.done};

    // Launch into the sequencer
    assign sif.start = launch;
    assign sif.read_only = b_act[vpb_pkg::ACT_RDONLY_BIT];
    assign sif.mask = b_mask;
    assign sif.wbytes = cmd_r[vpb_pkg::BYTE_WR0*8 +: 64];

    // ---------------------------------------------------------------
    // Read channel decode
    // ---------------------------------------------------------------
    wire [7:0] ra = s_axi_araddr;
    wire [31:0] st_word = {7'h00, sect_r, 15'h0000, busy_r};
    logic [31:0] rd_val;
    logic rd_ok;
    always_comb begin
        rd_val = 32'h0000_0000;
        rd_ok = 1'b1;
        if (ra[7:4] == 4'h0) begin
            rd_val = cmd_r[ra[3:2]*32 +: 32];
        end else if (ra == vpb_pkg::ADDR_CTRL) begin
            rd_val = {16'h0000, sig_r, 8'h00};
        end else if (ra == vpb_pkg::ADDR_STAT) begin
            rd_val = st_word;
        end else if (ra == vpb_pkg::ADDR_RDLO) begin
            rd_val = res_r[31:0];
        end else if (ra == vpb_pkg::ADDR_RDHI) begin
            rd_val = res_r[63:32];
        end else if (ra == vpb_pkg::ADDR_ISTAT) begin
            rd_val = {29'h0000_0000, ist_r};
        end else if (ra == vpb_pkg::ADDR_IMASK) begin
            rd_val = {29'h0000_0000, imask_r};
        end else begin
            rd_ok = 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // AXI handshakes
    // ---------------------------------------------------------------
    // Address and data latched independently
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            bvalid_r <= 1'b0;
            bresp_r <= vpb_pkg::RESP_OKAY;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else begin
            if (awready_r && s_axi_awvalid) begin
                awready_r <= 1'b0;
                awaddr_r <= s_axi_awaddr;
            end
            if (wready_r && s_axi_wvalid) begin
                wready_r <= 1'b0;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_go) begin
                bvalid_r <= 1'b1;
                bresp_r <= wr_ok ? vpb_pkg::RESP_OKAY :
                           vpb_pkg::RESP_SLVERR;
            end
            if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
                awready_r <= 1'b1;
                wready_r <= 1'b1;
            end
        end
    end

    // Read answered one cycle after address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= vpb_pkg::RESP_OKAY;
        end else if (arready_r && s_axi_arvalid) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= rd_val;
            rresp_r <= rd_ok ? vpb_pkg::RESP_OKAY :
                       vpb_pkg::RESP_SLVERR;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // Software registers
    // ---------------------------------------------------------------
    // Command block, signature and interrupt mask, byte strobed
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd_r <= '0;
            sig_r <= vpb_pkg::SIG_RESET;
            imask_r <= 3'h0;
        end else if (wr_go) begin
            if (sel_cmd) begin
                cmd_r[widx*32 +: 32] <= (cmd_r[widx*32 +: 32] &
                    ~bmask) | wbits;
            end
            if (sel_ctrl && wstrb_r[1]) begin
                sig_r <= wdata_r[vpb_pkg::CTRL_SIG_LSB +: 8];
            end
            if (sel_imask && wstrb_r[0]) begin
                imask_r <= wdata_r[2:0];
            end
        end
    end

    // Busy flag, block size and read result
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy_r <= 1'b0;
            sect_r <= 9'h000;
            res_r <= 64'h0000_0000_0000_0000;
        end else begin
            if (launch) begin
                busy_r <= 1'b1;
                sect_r <= sect;
            end else if (sif.done) begin
                busy_r <= 1'b0;
            end
            if (sif.done && sif.read_only) begin
                res_r <= sif.rbytes;
            end
        end
    end

    // ---------------------------------------------------------------
    // Interrupts
    // ---------------------------------------------------------------
    wire ist_clr_en = wr_go && sel_ist && wstrb_r[0];
    wire [2:0] ist_clr = ist_clr_en ? wdata_r[2:0] : 3'h0;

    // Sticky events, set beats clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ist_r <= 3'h0;
            irq_r <= 1'b0;
        end else begin
            ist_r <= (ist_r & ~ist_clr) | ev;
            irq_r <= |(((ist_r & ~ist_clr) | ev) & imask_r);
        end
    end

    // Outputs from flops
    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign irq = irq_r;
endmodule

/* tb/vpb_drive_model.sv */
`timescale 1ns/10ps
module vpb_drive_model (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Taskfile port
    input wire logic tf_alt,
    input wire logic [2:0] tf_addr,
    input wire logic tf_rd,
    input wire logic tf_wr,
    input wire logic [7:0] tf_wdata,
    output logic [7:0] tf_rdata,
    output logic tf_ack,
    // Completed accesses
    output logic [7:0] acc_cnt
);
    logic [7:0] regs_r [8];
    logic [1:0] wait_r;
    wire [2:0] idx = tf_alt ? 3'h0 : tf_addr;
    // Answer after 0 to 3 waits; idle data toggles so it is never stale
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tf_ack <= 1'h0;
            wait_r <= 2'h0;
            acc_cnt <= 8'h00;
            tf_rdata <= 8'h00;
            for (int i = 0; i < 8; i++) regs_r[i] <= 8'hA0 + 8'(i);
        end else if ((tf_rd || tf_wr) && !tf_ack) begin
            if (wait_r != acc_cnt[1:0]) begin
                wait_r <= wait_r + 2'h1;
                tf_rdata <= ~tf_rdata;
            end else begin
                tf_ack <= 1'h1;
                wait_r <= 2'h0;
                acc_cnt <= acc_cnt + 8'h01;
                tf_rdata <= tf_wr ? ~tf_rdata : regs_r[idx];
                if (tf_wr) regs_r[idx] <= tf_wdata;
            end
        end else begin
            tf_ack <= 1'h0;
            tf_rdata <= ~tf_rdata;
        end
    end
endmodule

/* tb/vpb_assertions.sv */
`timescale 1ns/10ps
module vpb_assertions (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Taskfile port
    input wire logic tf_alt,
    input wire logic [2:0] tf_addr,
    input wire logic tf_rd,
    input wire logic tf_wr,
    input wire logic [7:0] tf_wdata,
    input wire logic tf_ack
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire stb = tf_rd | tf_wr;
    wire [3:0] cur = tf_alt ? 4'h1 : {1'h0, tf_addr} + 4'h1;
    wire go = s_axi_awvalid & s_axi_awready &
        (s_axi_awaddr == vpb_pkg::ADDR_CTRL);
    logic stb_d_r;
    logic [3:0] last_r;
    // Remember the last index, fresh for each command
    always_ff @(posedge aclk) begin
        stb_d_r <= aresetn & stb;
        if (!aresetn || go) last_r <= 4'h0;
        else if (stb && !stb_d_r) last_r <= cur;
    end
    sequence s_wait;
        stb && !tf_ack;
    endsequence
    sequence s_done;
        stb && tf_ack;
    endsequence
    a_one_strobe: assert property (!(tf_rd && tf_wr))
        else $error("read and write strobes together");
    a_req_hold: assert property (s_wait |=>
        stb && $stable({tf_rd, tf_alt, tf_addr}))
        else $error("request changed before acknowledge");
    a_wdata_hold: assert property (tf_wr && !tf_ack |=>
        $stable(tf_wdata)) else $error("write byte changed");
    a_strobe_drop: assert property (s_done |=> !stb)
        else $error("no idle cycle after acknowledge");
    a_alt_index: assert property (stb && tf_alt |->
        tf_addr == vpb_pkg::TF_ALT_ADDR) else $error("bad alt address");
    a_prim_index: assert property (stb && !tf_alt |->
        tf_addr != 3'h0) else $error("bad primary address");
    a_ascending: assert property (stb && !stb_d_r |-> cur > last_r)
        else $error("access order not ascending");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read answer late");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
endmodule
bind vpb_top vpb_assertions u_vpb_assertions (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .tf_alt, .tf_addr, .tf_rd, .tf_wr, .tf_wdata, .tf_ack);

/* tb/testbench.sv */
`timescale 1ns/10ps
module testbench;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0;
    logic s_axi_wvalid = 1'h0;
    logic s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0;
    logic s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, tf_alt, tf_rd, tf_wr, tf_ack, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [2:0] tf_addr;
    logic [7:0] tf_wdata, tf_rdata, acc_cnt;
    logic [7:0] mir [8];
    logic [2:0] im = 3'h0;
    logic [1:0] wresp = 2'h0;
    logic [7:0] bad [3] = '{8'h03, 8'h81, 8'hFF};
    int miscompares = 0;
    int checks = 0;
    int cyc = 0;

    // Clock
    always #5 aclk = ~aclk;

    vpb_top u_vpb_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tf_alt, .tf_addr,
        .tf_rd, .tf_wr, .tf_wdata, .tf_rdata, .tf_ack, .irq);
    vpb_drive_model u_vpb_drive_model (.aclk, .aresetn, .tf_alt,
        .tf_addr, .tf_rd, .tf_wr, .tf_wdata, .tf_rdata, .tf_ack, .acc_cnt);

    // ------------------------------------------------------------
    // Bus and command tasks
    // ------------------------------------------------------------
    task automatic wrap_up;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        forever begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        wresp = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        // Ready comes late so the slave must hold its answer
        forever begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid && s_axi_rready) break;
            if (s_axi_rvalid) s_axi_rready <= 1'h1;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask

    task automatic run(input logic [7:0] sg, sb, act, msk, cnt,
                       input logic [63:0] w, input logic [2:0] ev);
        logic [31:0] d;
        logic [1:0] r;
        logic [7:0] c0;
        c0 = acc_cnt;
        wr(vpb_pkg::ADDR_CMD0, {msk, act, sb, sg});
        wr(vpb_pkg::ADDR_CMD1, {w[23:0], cnt});
        wr(vpb_pkg::ADDR_CMD2, w[55:24]);
        wr(vpb_pkg::ADDR_CMD3, {24'h00_0000, w[63:56]});
        wr(vpb_pkg::ADDR_CTRL, {16'h0000, vpb_pkg::SIG_RESET, 8'h01});
        d = 32'h0000_0000;
        while (d == 32'h0000_0000) rd(vpb_pkg::ADDR_ISTAT, d, r);
        chk(d, {29'h0000_0000, ev});
        chk(32'(acc_cnt - c0), ev[0] ? $countones(msk) : 0);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, {31'h0, |(ev & im)});
        wr(vpb_pkg::ADDR_ISTAT, d);
        rd(vpb_pkg::ADDR_ISTAT, d, r);
        chk({d[31:0]}, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0000_0000);
        if (ev[0]) begin
            rd(vpb_pkg::ADDR_STAT, d, r);
            chk({23'h0, d[24:16]}, cnt == 8'h00 ?
                {23'h0, vpb_pkg::SECT_ZERO} : {24'h00_0000, cnt});
            for (int i = 0; i < 8; i++)
                if (!act[0] && msk[i]) mir[i] = w[i*8+:8];
        end
    endtask

    task automatic rdres(input logic [7:0] m);
        logic [31:0] d;
        logic [1:0] r;
        logic [63:0] e;
        for (int i = 0; i < 8; i++) e[i*8+:8] = m[i] ? mir[i] : 8'h00;
        run(vpb_pkg::SIG_RESET, vpb_pkg::SUBCMD_CODE, 8'h01, m, 8'h08,
            '0, 3'h1);
        rd(vpb_pkg::ADDR_RDLO, d, r);
        chk(d, e[31:0]);
        rd(vpb_pkg::ADDR_RDHI, d, r);
        chk(d, e[63:32]);
        $display("test read mask %h done", m);
    endtask

    // Cut a hang short
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 30000) begin
            miscompares++;
            wrap_up;
        end
    end

    // Main sequence
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        for (int i = 0; i < 8; i++) mir[i] = 8'hA0 + 8'(i);
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        rd(vpb_pkg::ADDR_CTRL, d, r);
        chk(d, {16'h0000, vpb_pkg::SIG_RESET, 8'h00});
        rd(vpb_pkg::ADDR_STAT, d, r);
        chk({31'h0, d[0]}, 32'h0000_0000);
        rd(vpb_pkg::ADDR_IMASK, d, r);
        chk(d, 32'h0000_0000);
        rd(8'h40, d, r);
        chk({30'h0, r}, {30'h0, vpb_pkg::RESP_SLVERR});
        wr(8'h40, 32'h0000_0001);
        chk({30'h0, wresp}, {30'h0, vpb_pkg::RESP_SLVERR});
        wr(vpb_pkg::ADDR_CTRL, 32'h0000_3C00);
        rd(vpb_pkg::ADDR_CTRL, d, r);
        chk(d, 32'h0000_3C00);
        wr(vpb_pkg::ADDR_CTRL, {16'h0000, vpb_pkg::SIG_RESET, 8'h00});
        $display("test reset done");
        rdres(8'hA5);
        run(vpb_pkg::SIG_RESET, vpb_pkg::SUBCMD_CODE, 8'h00, 8'h81,
            8'h00, 64'h7766_5544_3322_1100, 3'h1);
        rdres(8'hFF);
        // Counts as a drive would be programmed
        for (int k = 0; k < 8; k++)
            run(vpb_pkg::SIG_RESET, vpb_pkg::SUBCMD_CODE, 8'h01, 8'h00,
                8'h01 << k, '0, 3'h1);
        $display("test legal counts done");
        im = 3'h1;
        wr(vpb_pkg::ADDR_IMASK, {29'h0000_0000, im});
        foreach (bad[k])
            run(vpb_pkg::SIG_RESET, vpb_pkg::SUBCMD_CODE, 8'h00, 8'hFF,
                bad[k], '1, 3'h2);
        rdres(8'hFF);
        im = 3'h7;
        wr(vpb_pkg::ADDR_IMASK, {29'h0000_0000, im});
        run(vpb_pkg::SIG_RESET ^ 8'h01, vpb_pkg::SUBCMD_CODE, 8'h00,
            8'hFF, 8'h08, '1, 3'h4);
        run(vpb_pkg::SIG_RESET, 8'h25, 8'h00, 8'hFF, 8'h08, '1, 3'h4);
        $display("test reject done");
        rdres(8'h3C);
        wrap_up;
    end
endmodule
